//--- pkg/thc_pkg.sv
// Constants, types and encodings for the thermometer and thermostat core.
// What this block does
// - Temperatures are 9-bit two's complement, half-degree steps.
// - Over output high while temperature at or above upper.
// - Under output high while temperature at or below lower.
// - Hysteresis output sets at upper, clears at lower.
// - Done bit is 1 when idle, resets to 1.
// - Sticky over/under flags, cleared by writing 0.
// - Busy bit high during nonvolatile write, up to 10 ms.
// - Port select 0 lets clock pin trigger conversions.
// - Single mode converts once per start, else continuously.
// - Single mode holds outputs from last conversion.
// - Serial port always works; select 1 blocks pin triggering.
// - Short low pulse converts once; held low converts continuously.
// - Pin trigger overrides single conversion mode.
// - Enable frames transfers; falling enable aborts and releases data.
// - Read bits launch on falling edge; released while clock high.
// - All values shift least significant bit first.
// - Command 0xAA returns latest temperature in nine clocks.
// - Commands 0x01/0x02 write upper/lower trip values.
// - Commands 0xA1/0xA2 read upper/lower trip values.
// - 0xA0 reads residual count; 0xA9 loads and reads slope.
// - Command 0xEE starts conversion, takes no data.
// - Command 0x22 stops continuous conversion after current one.
// - 0x0C writes, 0xAC reads the 8-bit configuration.
// - Temperature register resets to minus 60 degrees.
// - Zeros follow the last bit of any read.
`default_nettype none
package thc_pkg;
	localparam int TEMP_W = 9;
	typedef logic [TEMP_W-1:0] thc_temp_t;
	localparam logic [7:0] CMD_RD_TEMP = 8'haa;
	localparam logic [7:0] CMD_RD_COUNT = 8'ha0;
	localparam logic [7:0] CMD_RD_SLOPE = 8'ha9;
	localparam logic [7:0] CMD_START = 8'hee;
	localparam logic [7:0] CMD_STOP = 8'h22;
	localparam logic [7:0] CMD_WR_UPPER = 8'h01;
	localparam logic [7:0] CMD_WR_LOWER = 8'h02;
	localparam logic [7:0] CMD_RD_UPPER = 8'ha1;
	localparam logic [7:0] CMD_RD_LOWER = 8'ha2;
	localparam logic [7:0] CMD_WR_CFG = 8'h0c;
	localparam logic [7:0] CMD_RD_CFG = 8'hac;
	localparam logic [3:0] CMD_BITS = 4'h8;
	localparam logic [3:0] WORD_BITS = 4'h9;
	localparam logic [3:0] CFG_BITS = 4'h8;
	localparam int CFG_DONE = 7;
	localparam int CFG_OVER = 6;
	localparam int CFG_UNDER = 5;
	localparam int CFG_NVBUSY = 4;
	localparam int CFG_ONE = 3;
	localparam int CFG_ZERO = 2;
	localparam int CFG_PORTSEL = 1;
	localparam int CFG_SINGLE = 0;
	localparam logic [7:0] CFG_RST = 8'h88;
	localparam thc_temp_t TEMP_RST = 9'h188;
	localparam thc_temp_t UPPER_RST = 9'h01e;
	localparam thc_temp_t LOWER_RST = 9'h014;
	localparam thc_temp_t COUNT_RST = 9'h000;
	localparam int CLK_HZ = 25_000_000;
	localparam int NV_BUSY_MS = 10;
	localparam int CONV_MS = 750;
	localparam int NV_BUSY_CYC = (CLK_HZ / 1000) * NV_BUSY_MS;
	localparam int CONV_CYC = (CLK_HZ / 1000) * CONV_MS;
	typedef enum logic [3:0] {
		LK_CMD = 4'b0001,
		LK_READ = 4'b0010,
		LK_WRITE = 4'b0100,
		LK_IGNORE = 4'b1000
	} thc_link_t;
endpackage : thc_pkg
`default_nettype wire

//--- hdl/thc_top.sv
// Thermometer and thermostat core: three-wire port, conversion, thermostat.
`default_nettype none
module thc_top #(
	parameter int unsigned NV_BUSY_CYCLES = thc_pkg::NV_BUSY_CYC,
	parameter int unsigned CONV_CYCLES = thc_pkg::CONV_CYC
) (
	input wire logic clk, // system clock, 25 MHz
	input wire logic reset, // asynchronous reset, active high
	input wire logic clockOrTriggerPin, // serial clock / convert pin
	input wire logic transferEn, // transfer enable, active high
	input wire logic dqIn, // data line level
	output logic dqOut, // data line drive value
	output logic dqOe, // data line drive enable
	input wire thc_pkg::thc_temp_t tempIn, // sensor result
	input wire thc_pkg::thc_temp_t countIn, // residual count
	input wire thc_pkg::thc_temp_t slopeIn, // slope accumulator
	output logic overOut, // over-limit output
	output logic underOut, // under-limit output
	output logic hystOut // hysteresis output
);
	import thc_pkg::*;

	function automatic logic tempGe(input thc_temp_t a, input thc_temp_t b);
		return $signed(a) >= $signed(b);
	endfunction : tempGe

	// Link-side state that the enable pin clears.
	typedef struct packed {
		thc_link_t state;
		logic [3:0] bitCnt;
		logic [7:0] cmd;
		thc_temp_t shift;
	} thc_lnk_t;

	// Link-side event mailbox; survives the enable so no toggle is lost.
	typedef struct packed {
		logic evtTog;
		logic [7:0] evtCmd;
		thc_temp_t evtData;
	} thc_mbx_t;

	// Falling-edge launch stage.
	typedef struct packed {
		logic dqBit;
		logic drive;
	} thc_fall_t;

	typedef struct packed {
		logic [2:0] enSync;
		logic [2:0] pinSync;
		logic [2:0] evtSync;
		logic enHeld;
		logic pinHeld;
		logic evtHeld;
		thc_temp_t temp;
		thc_temp_t upperTripValue;
		thc_temp_t lowerTripValue;
		thc_temp_t count;
		thc_temp_t slope;
		logic singleConversionMode;
		logic portSelect;
		logic overFlag;
		logic underFlag;
		logic converting;
		logic continuous;
		logic [31:0] convCnt;
		logic nonvolatileBusy;
		logic [31:0] nvCnt;
		logic overQ;
		logic underQ;
		logic hystQ;
		thc_temp_t pubTemp;
		thc_temp_t pubUpper;
		thc_temp_t pubLower;
		thc_temp_t pubCount;
		thc_temp_t pubSlope;
		logic [7:0] pubCfg;
	} thc_sys_t;

	thc_lnk_t lnk_q, lnk_d;
	thc_mbx_t mbx_q, mbx_d;
	thc_fall_t fall_q, fall_d;
	thc_sys_t sys_q, sys_d;
	logic linkRst;
	logic [3:0] needBits;
	logic [7:0] cfgNow;
	logic evtSeen;
	logic pinFell;
	logic standalone;

	// Dropping the enable clears the link logic at once, even with the
	// serial clock stopped.
	assign linkRst = reset | ~transferEn;

	always_comb begin
		cfgNow = 8'h00;
		cfgNow[CFG_DONE] = ~sys_q.converting;
		cfgNow[CFG_OVER] = sys_q.overFlag;
		cfgNow[CFG_UNDER] = sys_q.underFlag;
		cfgNow[CFG_NVBUSY] = sys_q.nonvolatileBusy;
		cfgNow[CFG_ONE] = 1'b1;
		cfgNow[CFG_ZERO] = 1'b0;
		cfgNow[CFG_PORTSEL] = sys_q.portSelect;
		cfgNow[CFG_SINGLE] = sys_q.singleConversionMode;
	end

	// Link logic on the rising serial clock edge. The published copies it
	// reads are frozen in the system domain while the enable is high, so
	// they are stable long before the command byte completes.
	always_comb begin
		lnk_d = lnk_q;
		mbx_d = mbx_q;
		needBits = (lnk_q.cmd == CMD_WR_CFG) ? CFG_BITS : WORD_BITS;
		unique case (lnk_q.state)
			LK_CMD: begin
				lnk_d.cmd = {dqIn, lnk_q.cmd[7:1]};
				lnk_d.bitCnt = lnk_q.bitCnt + 4'h1;
				if (lnk_q.bitCnt == CMD_BITS - 4'h1) begin
					lnk_d.bitCnt = 4'h0;
					lnk_d.shift = '0;
					lnk_d.state = LK_READ;
					case (lnk_d.cmd)
						CMD_RD_TEMP: lnk_d.shift = sys_q.pubTemp;
						CMD_RD_UPPER: lnk_d.shift = sys_q.pubUpper;
						CMD_RD_LOWER: lnk_d.shift = sys_q.pubLower;
						CMD_RD_COUNT: lnk_d.shift = sys_q.pubCount;
						CMD_RD_CFG: lnk_d.shift = {1'b0, sys_q.pubCfg};
						CMD_RD_SLOPE: begin
							lnk_d.shift = sys_q.pubSlope;
							mbx_d.evtTog = ~mbx_q.evtTog;
							mbx_d.evtCmd = lnk_d.cmd;
						end
						CMD_WR_UPPER, CMD_WR_LOWER, CMD_WR_CFG: begin
							lnk_d.state = LK_WRITE;
						end
						CMD_START, CMD_STOP: begin
							lnk_d.state = LK_IGNORE;
							mbx_d.evtTog = ~mbx_q.evtTog;
							mbx_d.evtCmd = lnk_d.cmd;
						end
						default: lnk_d.state = LK_IGNORE;
					endcase
				end
			end
			LK_READ: begin
				// Zero fill lets extra clocks past the top bit read as 0.
				lnk_d.shift = {1'b0, lnk_q.shift[TEMP_W-1:1]};
			end
			LK_WRITE: begin
				lnk_d.shift = {dqIn, lnk_q.shift[TEMP_W-1:1]};
				lnk_d.bitCnt = lnk_q.bitCnt + 4'h1;
				if (lnk_q.bitCnt == needBits - 4'h1) begin
					lnk_d.state = LK_IGNORE;
					mbx_d.evtTog = ~mbx_q.evtTog;
					mbx_d.evtCmd = lnk_q.cmd;
					mbx_d.evtData = (needBits == CFG_BITS) ?
						{1'b0, lnk_d.shift[TEMP_W-1:1]} : lnk_d.shift;
				end
			end
			LK_IGNORE: begin
				lnk_d = lnk_q;
			end
		endcase
	end

	always_ff @(posedge clockOrTriggerPin or posedge linkRst) begin
		if (linkRst) begin
			lnk_q <= '{state: LK_CMD, bitCnt: 4'h0, cmd: 8'h00, shift: '0};
		end else begin
			lnk_q <= lnk_d;
		end
	end

	always_ff @(posedge clockOrTriggerPin or posedge reset) begin
		if (reset) begin
			mbx_q <= '0;
		end else begin
			mbx_q <= mbx_d;
		end
	end

	always_comb begin
		fall_d.dqBit = lnk_q.shift[0];
		fall_d.drive = (lnk_q.state == LK_READ);
	end

	always_ff @(negedge clockOrTriggerPin or posedge linkRst) begin
		if (linkRst) begin
			fall_q <= '0;
		end else begin
			fall_q <= fall_d;
		end
	end

	assign dqOut = fall_q.dqBit;
	// The data line must let go while the clock is high, which a register
	// alone cannot do within the same half period.
	assign dqOe = fall_q.drive & ~clockOrTriggerPin;

	// System domain.
	always_comb begin
		sys_d = sys_q;
		sys_d.enSync = {sys_q.enSync[1:0], transferEn};
		sys_d.pinSync = {sys_q.pinSync[1:0], clockOrTriggerPin};
		sys_d.evtSync = {sys_q.evtSync[1:0], mbx_q.evtTog};
		if (sys_q.enSync[2] == sys_q.enSync[1]) begin
			sys_d.enHeld = sys_q.enSync[1];
		end
		pinFell = 1'b0;
		if (sys_q.pinSync[2] == sys_q.pinSync[1]) begin
			sys_d.pinHeld = sys_q.pinSync[1];
			pinFell = sys_q.pinHeld & ~sys_q.pinSync[1];
		end
		evtSeen = 1'b0;
		if (sys_q.evtSync[2] == sys_q.evtSync[1]) begin
			sys_d.evtHeld = sys_q.evtSync[1];
			evtSeen = sys_q.evtHeld ^ sys_q.evtSync[1];
		end
		// The enable and the pin pass equally deep filters, so a serial
		// clock that follows the enable closely could pass for a convert
		// request; the freshly agreed enable closes that gap.
		standalone = ~sys_q.portSelect & ~sys_q.enHeld &
			~sys_d.enHeld;

		if (sys_q.nonvolatileBusy) begin
			sys_d.nvCnt = sys_q.nvCnt + 32'h1;
			if (sys_q.nvCnt == 32'(NV_BUSY_CYCLES - 1)) begin
				sys_d.nonvolatileBusy = 1'b0;
				sys_d.nvCnt = '0;
			end
		end

		// Mailbox fields are stable for many system cycles around a toggle.
		if (evtSeen) begin
			unique case (mbx_q.evtCmd)
				CMD_START: begin
					sys_d.converting = 1'b1;
					sys_d.continuous = ~sys_q.singleConversionMode;
				end
				CMD_STOP: sys_d.continuous = 1'b0;
				CMD_WR_UPPER: sys_d.upperTripValue = mbx_q.evtData;
				CMD_WR_LOWER: sys_d.lowerTripValue = mbx_q.evtData;
				CMD_WR_CFG: begin
					sys_d.portSelect = mbx_q.evtData[CFG_PORTSEL];
					sys_d.singleConversionMode = mbx_q.evtData[CFG_SINGLE];
					sys_d.overFlag = sys_q.overFlag & mbx_q.evtData[CFG_OVER];
					sys_d.underFlag =
						sys_q.underFlag & mbx_q.evtData[CFG_UNDER];
				end
				CMD_RD_SLOPE: sys_d.count = sys_q.slope;
				default: sys_d.converting = sys_q.converting;
			endcase
			if (mbx_q.evtCmd == CMD_WR_UPPER || mbx_q.evtCmd == CMD_WR_LOWER ||
				mbx_q.evtCmd == CMD_WR_CFG) begin
				sys_d.nonvolatileBusy = 1'b1;
				sys_d.nvCnt = '0;
			end
		end

		// A falling pin starts one conversion; while it stays low the
		// conversions chain, whatever the single mode bit says.
		if (standalone && pinFell) begin
			sys_d.converting = 1'b1;
		end

		if (sys_q.converting) begin
			sys_d.convCnt = sys_q.convCnt + 32'h1;
			if (sys_q.convCnt == 32'(CONV_CYCLES - 1)) begin
				sys_d.convCnt = '0;
				sys_d.temp = tempIn;
				sys_d.count = countIn;
				sys_d.slope = slopeIn;
				sys_d.overQ = tempGe(tempIn, sys_q.upperTripValue);
				sys_d.underQ = tempGe(sys_q.lowerTripValue, tempIn);
				if (tempGe(tempIn, sys_q.upperTripValue)) begin
					sys_d.hystQ = 1'b1;
					sys_d.overFlag = 1'b1;
				end else if (tempGe(sys_q.lowerTripValue, tempIn)) begin
					sys_d.hystQ = 1'b0;
				end
				if (tempGe(sys_q.lowerTripValue, tempIn)) begin
					sys_d.underFlag = 1'b1;
				end
				// Outputs change only here, so single mode holds them.
				sys_d.converting = sys_d.continuous |
					(standalone & ~sys_q.pinHeld);
			end
		end

		if (!sys_q.enHeld) begin
			sys_d.pubTemp = sys_q.temp;
			sys_d.pubUpper = sys_q.upperTripValue;
			sys_d.pubLower = sys_q.lowerTripValue;
			sys_d.pubCount = sys_q.count;
			sys_d.pubSlope = sys_q.slope;
			sys_d.pubCfg = cfgNow;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sys_q <= '0;
			sys_q.temp <= TEMP_RST;
			sys_q.pubTemp <= TEMP_RST;
			sys_q.upperTripValue <= UPPER_RST;
			sys_q.pubUpper <= UPPER_RST;
			sys_q.lowerTripValue <= LOWER_RST;
			sys_q.pubLower <= LOWER_RST;
			sys_q.count <= COUNT_RST;
			sys_q.pubCfg <= CFG_RST;
			// The pin idles high, so its filter starts there and a pin
			// held low through reset still counts as a convert request.
			sys_q.pinSync <= '1;
			sys_q.pinHeld <= 1'b1;
		end else begin
			sys_q <= sys_d;
		end
	end

	assign overOut = sys_q.overQ;
	assign underOut = sys_q.underQ;
	assign hystOut = sys_q.hystQ;
endmodule : thc_top
`default_nettype wire

//--- tb/thc_props.sv
// Port checker for the thermometer and thermostat core.
`default_nettype none
module thc_props #(
	parameter int unsigned NV_BUSY_CYCLES = 20,
	parameter int unsigned CONV_CYCLES = 40
) (
	input wire logic clk, // system clock
	input wire logic reset, // async reset
	input wire logic clockOrTriggerPin, // link clock
	input wire logic transferEn, // transfer enable
	input wire logic dqIn, // data line
	input wire logic dqOut, // drive value
	input wire logic dqOe, // drive enable
	input wire thc_pkg::thc_temp_t tempIn, // sensor result
	input wire thc_pkg::thc_temp_t countIn, // residual count
	input wire thc_pkg::thc_temp_t slopeIn, // slope
	input wire logic overOut, // over output
	input wire logic underOut, // under output
	input wire logic hystOut // hysteresis output
);
	timeunit 1ns;
	timeprecision 1ns;
	import thc_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic [7:0] quietQ;
	logic [2:0] outsQ;
	// Outputs move only at conversion ends, so changes sit far apart.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			quietQ <= 8'hff;
			outsQ <= 3'h0;
		end else begin
			outsQ <= {overOut, underOut, hystOut};
			if ({overOut, underOut, hystOut} != outsQ)
				quietQ <= 8'h00;
			else if (quietQ != 8'hff)
				quietQ <= quietQ + 8'h01;
		end
	end
	sequence s_enOpen;
		$rose(transferEn);
	endsequence
	property p_relOff; !transferEn |-> !dqOe; endproperty
	property p_relHigh; clockOrTriggerPin |-> !dqOe; endproperty
	property p_cmdQuiet; s_enOpen |-> !dqOe [*5]; endproperty
	property p_hystRise; $rose(hystOut) |-> overOut; endproperty
	property p_hystFall; $fell(hystOut) |-> underOut; endproperty
	property p_hystSet; overOut && !underOut |-> hystOut; endproperty
	property p_hystClr; underOut && !overOut |-> !hystOut; endproperty
	property p_quiet;
		({overOut, underOut, hystOut} != outsQ) |-> quietQ >= CONV_CYCLES - 4;
	endproperty
	a_relOff: assert property (p_relOff)
		else $error("data line driven outside a transfer");
	a_relHigh: assert property (p_relHigh)
		else $error("data line driven while clock high");
	a_cmdQuiet: assert property (p_cmdQuiet)
		else $error("data line driven during command");
	a_hystRise: assert property (p_hystRise)
		else $error("hysteresis rose without over");
	a_hystFall: assert property (p_hystFall)
		else $error("hysteresis fell without under");
	a_hystSet: assert property (p_hystSet)
		else $error("over high with hysteresis low");
	a_hystClr: assert property (p_hystClr)
		else $error("under high with hysteresis high");
	a_quiet: assert property (p_quiet)
		else $error("outputs changed between conversions");
endmodule : thc_props
bind thc_top thc_props #(
	.NV_BUSY_CYCLES(NV_BUSY_CYCLES),
	.CONV_CYCLES(CONV_CYCLES)
) u_props (.clk, .reset, .clockOrTriggerPin, .transferEn, .dqIn, .dqOut,
	.dqOe, .tempIn, .countIn, .slopeIn, .overOut, .underOut, .hystOut);
`default_nettype wire

//--- tb/thc_host.sv
// Host model that drives the three-wire port and the convert pin.
`default_nettype none
module thc_host (
	output logic sck, // link clock, idles high
	output logic en, // transfer enable
	output logic dqIn, // resolved data line
	input wire logic dqOut, // device drive value
	input wire logic dqOe, // device drive enable
	output logic sawDrive // device drove in this frame
);
	timeunit 1ns;
	timeprecision 1ns;
	logic hostOe = 1'b0;
	logic hostD = 1'b0;
	logic relLvl = 1'b0;
	initial begin
		sck = 1'b1;
		en = 1'b0;
		sawDrive = 1'b0;
	end
	// A released line keeps toggling so a stale bit can never be read.
	always #7 relLvl = ~relLvl;
	assign dqIn = dqOe ? dqOut : (hostOe ? hostD : relLvl);
	always @(posedge dqOe) sawDrive = 1'b1;
	task automatic xfer(input logic [7:0] cmd, input int nw,
		input logic [8:0] wd, input int nr, output logic [15:0] rd);
		logic [16:0] sh;
		sh = {wd, cmd};
		rd = 16'h0000;
		sawDrive = 1'b0;
		#5 en = 1'b1;
		for (int i = 0; i < 8 + nw + nr; i++) begin
			#16 sck = 1'b0;
			hostOe = (i < 8 + nw);
			hostD = (i < 17) ? sh[i] : 1'b0;
			#16;
			if (i >= 8 + nw)
				rd[i - 8 - nw] = dqIn;
			sck = 1'b1;
		end
		#16 hostOe = 1'b0;
		en = 1'b0;
		#400;
	endtask : xfer
	task automatic pulse(input int lowNs);
		#16 sck = 1'b0;
		#(lowNs) sck = 1'b1;
	endtask : pulse
endmodule : thc_host
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the thermometer and thermostat core.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import thc_pkg::*;
	logic clk, reset, sck, en, dqIn, dqOut, dqOe, sawDrive;
	logic overOut, underOut, hystOut;
	thc_temp_t tempIn, countIn, slopeIn;
	int mismatches = 0;
	int compares = 0;
	logic [15:0] rdv;
	thc_top #(.NV_BUSY_CYCLES(20), .CONV_CYCLES(40)) u_dut (
		.clk(clk), .reset(reset), .clockOrTriggerPin(sck), .transferEn(en),
		.dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .tempIn(tempIn),
		.countIn(countIn), .slopeIn(slopeIn), .overOut(overOut),
		.underOut(underOut), .hystOut(hystOut));
	thc_host u_host (.sck(sck), .en(en), .dqIn(dqIn), .dqOut(dqOut),
		.dqOe(dqOe), .sawDrive(sawDrive));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
			$display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
		if (seen !== exp)
			mismatches++;
	endtask : check
	task automatic rd(input logic [7:0] c, input int n, input logic [15:0] e);
		u_host.xfer(c, 0, 9'h000, n, rdv);
		check(rdv, e);
	endtask : rd
	// Writes reach nonvolatile cells, so leave the busy time to run out.
	task automatic wr(input logic [7:0] c, input int n, input logic [8:0] v);
		u_host.xfer(c, n, v, 0, rdv);
		#1200;
	endtask : wr
	task automatic setIn(input thc_temp_t t);
		@(negedge clk);
		tempIn = t;
	endtask : setIn
	task automatic outs(input logic [2:0] e);
		@(negedge clk);
		check({13'h0000, overOut, underOut, hystOut},
			{13'h0000, e});
	endtask : outs
	task automatic t_reset;
		rd(8'hac, 8, 16'h0088);
		rd(8'haa, 16, 16'h0188);
		check({15'h0000, sawDrive}, 16'h0001);
		rd(8'haa, 4, 16'h0008);
		rd(8'ha1, 9, 16'h001e);
		rd(8'ha2, 9, 16'h0014);
		u_host.xfer(8'h55, 0, 9'h000, 9, rdv);
		check({15'h0000, sawDrive}, 16'h0000);
	endtask : t_reset
	task automatic t_write;
		u_host.xfer(8'h01, 9, 9'h032, 0, rdv);
		rd(8'hac, 8, 16'h0098);
		#1000;
		rd(8'hac, 8, 16'h0088);
		wr(8'h02, 9, 9'h1ce);
		rd(8'ha1, 9, 16'h0032);
		rd(8'ha2, 9, 16'h01ce);
	endtask : t_write
	task automatic t_single;
		wr(8'h0c, 8, 9'h001);
		setIn(9'h032);
		u_host.xfer(8'hee, 0, 9'h000, 0, rdv);
		rd(8'hac, 8, 16'h0009);
		#2000;
		outs(3'b101);
		rd(8'hac, 8, 16'h00c9);
		rd(8'haa, 9, 16'h0032);
		rd(8'ha0, 9, 16'h00a5);
		rd(8'ha9, 9, 16'h004b);
		rd(8'ha0, 9, 16'h004b);
		setIn(9'h1ce);
		#2500;
		outs(3'b101);
		u_host.xfer(8'hee, 0, 9'h000, 0, rdv);
		#2000;
		outs(3'b010);
		rd(8'hac, 8, 16'h00e9);
		wr(8'h0c, 8, 9'h021);
		rd(8'hac, 8, 16'h00a9);
	endtask : t_single
	task automatic t_stand;
		setIn(9'h000);
		u_host.pulse(200);
		#2000;
		outs(3'b000);
		wr(8'h0c, 8, 9'h003);
		setIn(9'h1ce);
		u_host.pulse(200);
		#2000;
		outs(3'b000);
	endtask : t_stand
	task automatic t_cont;
		wr(8'h0c, 8, 9'h002);
		u_host.xfer(8'hee, 0, 9'h000, 0, rdv);
		#2000;
		rd(8'haa, 9, 16'h01ce);
		setIn(9'h032);
		#2000;
		rd(8'haa, 9, 16'h0032);
		outs(3'b101);
		u_host.xfer(8'h22, 0, 9'h000, 0, rdv);
		#2000;
		setIn(9'h000);
		#4000;
		rd(8'haa, 9, 16'h0032);
	endtask : t_cont
	task automatic summarize;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize
	initial begin
		reset = 1'b1;
		tempIn = 9'h000;
		countIn = 9'h0a5;
		slopeIn = 9'h04b;
		repeat (4) @(negedge clk);
		reset = 1'b0;
		repeat (4) @(negedge clk);
		t_reset();
		t_write();
		t_single();
		t_stand();
		t_cont();
		summarize();
	end
	// The sequence needs about 60 us; three times that means a hang.
	initial begin
		#200000;
		mismatches++;
		summarize();
	end
endmodule : tb_top
`default_nettype wire
